// ### src/etp_top.sv
// Trace recorder, executed marks, cycle counter and probe cable logic.
// Assumes CPU strobes are one clock wide and at least three clocks apart.
`timescale 1ns/10ps
`default_nettype none

module etp_top #(
  parameter int ADDR_W  = 16,
  parameter int TRC_AW  = 13,
  parameter int CNT_W   = 24
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Emulation state
  input  wire logic                 real_time,
  input  wire logic                 run_start,
  input  wire logic                 brk_taken,
  // Instruction timing
  input  wire logic                 first_machine_phase,
  input  wire logic                 second_machine_phase,
  input  wire logic                 phase_first_half,
  input  wire logic                 first_word,
  input  wire logic                 table_read,
  input  wire logic [ADDR_W-1:0]    insn_addr,
  input  wire logic [1:0]           insn_cycles,
  // Code accesses of any kind
  input  wire logic                 code_access,
  input  wire logic [ADDR_W-1:0]    code_addr,
  // CPU state
  input  wire logic [3:0]           cpu_acc,
  input  wire logic [2:0]           cpu_flags_ahead,
  input  wire logic                 master_irq_enable_flag,
  input  wire logic [3:0]           cpu_cb,
  input  wire logic [3:0]           cpu_eb,
  input  wire logic [7:0]           cpu_hl,
  input  wire logic [7:0]           cpu_xy,
  input  wire logic [4:0]           cpu_sp,
  input  wire logic [3:0]           cpu_rsp,
  // Data memory writes
  input  wire logic                 ram_write,
  input  wire logic [11:0]          ram_addr,
  input  wire logic [3:0]           ram_data,
  // Probe cable
  input  wire logic                 external_break_in,
  input  wire logic                 probe_trace_in_bit0,
  input  wire logic                 probe_trace_in_bit1,
  input  wire logic                 probe_trace_in_bit2,
  input  wire logic                 probe_trace_in_bit3,
  output logic                      sync_out_n,
  // Break requests
  output logic                      ext_break_req,
  output logic                      ovf_break_req
);
  import etp_pkg::*;

  localparam int MAP_D = 1 << ADDR_W;
  localparam int TRC_D = 1 << TRC_AW;

  // Entry fields and sequencing assume these sizes
  generate
    if (ADDR_W != 16 || TRC_AW < 1 || TRC_AW > 15 || CNT_W < 2 || CNT_W > 31) begin : g_chk
      $error("etp_top: unsupported parameter values");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_a_reg;
  logic rst_n_reg;

  // Two stages so release never lands near an edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n_reg <= rst_a_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [ETP_CTRL_W-1:0] ctrl_reg;
  logic [31:0]           trc_trig_reg;
  logic [31:0]           cnt_trig_reg;
  logic [ADDR_W-1:0]     map_adr_reg;
  logic [TRC_AW-1:0]     trc_idx_reg;
  logic [TRC_AW-1:0]     wptr_reg;
  logic [CNT_W-1:0]      cycles_reg;
  logic [31:0]           rdata_next;
  logic                  bad_adr;

  logic                  te_mem   [MAP_D];
  logic                  sync_mem [MAP_D];
  logic                  mark_mem [MAP_D];
  logic [ETP_ENTRY_W-1:0] trc_mem [TRC_D];

  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire wr_en  = access & pwrite;

  wire sel_ctrl = (paddr == ETP_CTRL_OFS);
  wire sel_ttrg = (paddr == ETP_TRC_TRIG_OFS);
  wire sel_ctrg = (paddr == ETP_CNT_TRIG_OFS);
  wire sel_stat = (paddr == ETP_STATUS_OFS);
  wire sel_cyc  = (paddr == ETP_CYCLES_OFS);
  wire sel_madr = (paddr == ETP_MAP_ADR_OFS);
  wire sel_mdat = (paddr == ETP_MAP_DAT_OFS);
  wire sel_tidx = (paddr == ETP_TRC_IDX_OFS);
  wire sel_tw0  = (paddr == ETP_TRC_W0_OFS);
  wire sel_tw1  = (paddr == ETP_TRC_W1_OFS);
  wire sel_tw2  = (paddr == ETP_TRC_W2_OFS);

  // Trace entry word picked from the stored line
  function automatic logic [31:0] entry_word(input logic [ETP_ENTRY_W-1:0] e, input int w);
    logic [95:0] wide;
    wide = {{(96-ETP_ENTRY_W){1'b0}}, e};
    return wide[w*32 +: 32];
  endfunction

  wire etp_mode_e tmode = etp_mode_e'(ctrl_reg[ETP_C_TMODE +: 2]);
  wire etp_mode_e cmode = etp_mode_e'(ctrl_reg[ETP_C_CMODE +: 2]);
  wire [ETP_ENTRY_W-1:0] rd_entry = trc_mem[trc_idx_reg];
  wire [2:0] map_rd = {sync_mem[map_adr_reg], mark_mem[map_adr_reg], te_mem[map_adr_reg]};
  wire trc_open;
  wire cnt_open;

  // Read mux; unmapped offsets answer zero with an error
  always_comb begin
    rdata_next = 32'h0000_0000;
    bad_adr    = 1'b0;
    if (sel_ctrl) begin
      rdata_next = {{(32-ETP_CTRL_W){1'b0}}, ctrl_reg};
    end else if (sel_ttrg) begin
      rdata_next = trc_trig_reg;
    end else if (sel_ctrg) begin
      rdata_next = cnt_trig_reg;
    end else if (sel_stat) begin
      rdata_next = {12'h000, ovf_break_req, ext_break_req, cnt_open, trc_open,
                    {(16-TRC_AW){1'b0}}, wptr_reg};
    end else if (sel_cyc) begin
      rdata_next = {{(32-CNT_W){1'b0}}, cycles_reg};
    end else if (sel_madr) begin
      rdata_next = {{(32-ADDR_W){1'b0}}, map_adr_reg};
    end else if (sel_mdat) begin
      rdata_next = {29'h0000_0000, map_rd};
    end else if (sel_tidx) begin
      rdata_next = {{(32-TRC_AW){1'b0}}, trc_idx_reg};
    end else if (sel_tw0) begin
      rdata_next = entry_word(rd_entry, 0);
    end else if (sel_tw1) begin
      rdata_next = entry_word(rd_entry, 1);
    end else if (sel_tw2) begin
      rdata_next = entry_word(rd_entry, 2);
    end else begin
      bad_adr = 1'b1;
    end
  end

  // One access cycle; read data caught in the setup cycle
  assign pready = access;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
      pslverr <= bad_adr;
    end
  end

  // Writable registers
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg     <= ETP_CTRL_RST;
      trc_trig_reg <= 32'h0000_0000;
      cnt_trig_reg <= 32'h0000_0000;
      map_adr_reg  <= '0;
      trc_idx_reg  <= '0;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_reg <= pwdata[ETP_CTRL_W-1:0];
      if (sel_ttrg) trc_trig_reg <= pwdata;
      if (sel_ctrg) cnt_trig_reg <= pwdata;
      if (sel_madr) map_adr_reg <= pwdata[ADDR_W-1:0];
      if (sel_tidx) trc_idx_reg <= pwdata[TRC_AW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-address bits

  wire mark_set = real_time & code_access;
  wire map_wr   = wr_en & sel_mdat;

  // Software-only bits
  always_ff @(posedge clk) begin
    if (map_wr) begin
      te_mem[map_adr_reg]   <= pwdata[ETP_M_TE];
      sync_mem[map_adr_reg] <= pwdata[ETP_M_SYNC];
    end
  end

  // Hardware set is written last so it wins over a clear
  always_ff @(posedge clk) begin
    if (map_wr) mark_mem[map_adr_reg] <= pwdata[ETP_M_MARK];
    if (mark_set) mark_mem[code_addr] <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address windows

  wire trc_take;
  wire cnt_take;

  etp_trigger #(.ADDR_W(ADDR_W)) u_trc_trig (
    .clk         (clk),
    .rst_n       (rst_n_reg),
    .mode        (tmode),
    .start_en    (ctrl_reg[ETP_C_TSTART]),
    .stop_en     (ctrl_reg[ETP_C_TSTOP]),
    .start_addr  (trc_trig_reg[15:0]),
    .stop_addr   (trc_trig_reg[31:16]),
    .real_time   (real_time),
    .run_start   (run_start),
    .brk_taken   (brk_taken),
    .insn_strobe (first_machine_phase),
    .first_word  (first_word),
    .insn_addr   (insn_addr),
    .take        (trc_take),
    .open        (trc_open)
  );

  etp_trigger #(.ADDR_W(ADDR_W)) u_cnt_trig (
    .clk         (clk),
    .rst_n       (rst_n_reg),
    .mode        (cmode),
    .start_en    (ctrl_reg[ETP_C_CSTART]),
    .stop_en     (ctrl_reg[ETP_C_CSTOP]),
    .start_addr  (cnt_trig_reg[15:0]),
    .stop_addr   (cnt_trig_reg[31:16]),
    .real_time   (real_time),
    .run_start   (run_start),
    .brk_taken   (brk_taken),
    .insn_strobe (first_machine_phase),
    .first_word  (first_word),
    .insn_addr   (insn_addr),
    .take        (cnt_take),
    .open        (cnt_open)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Trace recorder

  logic [11:0]            radr_reg;
  logic [3:0]             rdat_reg;
  logic [ETP_ENTRY_W-1:0] pend_reg;
  logic                   pend_vld_reg;
  logic                   pend_dup_reg;
  logic                   dup_reg;
  logic [ETP_ENTRY_W-1:0] wr_line_reg;
  logic [ETP_ENTRY_W-1:0] commit_line;

  wire te_ok   = ~ctrl_reg[ETP_C_TOPT] | te_mem[insn_addr];
  wire rec     = trc_take & te_ok;
  wire [3:0] probe = {probe_trace_in_bit3, probe_trace_in_bit2,
                      probe_trace_in_bit1, probe_trace_in_bit0};
  wire insn_go = first_machine_phase & first_word;
  wire commit  = pend_vld_reg & (insn_go | brk_taken);

  // Last data-memory write; no reset, so indeterminate before one
  always_ff @(posedge clk) begin
    if (ram_write) begin
      radr_reg <= ram_addr;
      rdat_reg <= ram_data;
    end
  end

  // Entry of this instruction; flags filled at commit
  always_comb begin
    commit_line = pend_reg;
    commit_line[ETP_E_FLAG +: 4] = {master_irq_enable_flag, cpu_flags_ahead};
  end

  // Snapshot at first phase start, probe inputs latched here
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pend_reg     <= '0;
      pend_vld_reg <= 1'b0;
      pend_dup_reg <= 1'b0;
    end else if (rec) begin
      pend_reg     <= {probe, cpu_rsp, cpu_sp, cpu_xy, cpu_hl, cpu_eb, cpu_cb,
                       4'h0, rdat_reg, radr_reg, cpu_acc, insn_addr};
      pend_vld_reg <= 1'b1;
      pend_dup_reg <= table_read;
    end else if (commit) begin
      pend_vld_reg <= 1'b0;
    end
  end

  // Store writes; a table read repeats one clock later
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wptr_reg    <= '0;
      dup_reg     <= 1'b0;
      wr_line_reg <= '0;
    end else begin
      dup_reg <= commit & pend_dup_reg;
      if (commit) begin
        wr_line_reg <= commit_line;
      end
      if (commit | dup_reg) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (commit) begin
      trc_mem[wptr_reg] <= commit_line;
    end else if (dup_reg) begin
      trc_mem[wptr_reg] <= wr_line_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cycle counter

  wire [CNT_W:0] cyc_sum = {1'b0, cycles_reg} + {{(CNT_W-1){1'b0}}, insn_cycles};
  wire cyc_wr = wr_en & sel_cyc;

  // Adds the whole instruction at its first phase
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cycles_reg <= '0;
    end else if (cnt_take) begin
      cycles_reg <= cyc_sum[CNT_W-1:0];
    end else if (cyc_wr) begin
      cycles_reg <= pwdata[CNT_W-1:0];
    end
  end

  wire ovf_hit = cnt_take & cyc_sum[CNT_W] & ctrl_reg[ETP_C_OVF_EN];

  // Resume clears; a new overflow in that clock wins
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ovf_break_req <= 1'b0;
    end else if (ovf_hit) begin
      ovf_break_req <= 1'b1;
    end else if (run_start) begin
      ovf_break_req <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Probe cable

  logic xb_d_reg;
  logic xb_pend_reg;
  logic sync_hit_reg;

  wire xb_rise = external_break_in & ~xb_d_reg;
  wire xb_fire = xb_pend_reg & second_machine_phase;

  // Edge held until the next second phase start, or dropped when real time ends
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      xb_d_reg      <= 1'b0;
      xb_pend_reg   <= 1'b0;
      ext_break_req <= 1'b0;
    end else begin
      xb_d_reg      <= external_break_in;
      ext_break_req <= xb_fire;
      if (xb_rise & real_time & ctrl_reg[ETP_C_XBRK_EN]) begin
        xb_pend_reg <= 1'b1;
      end else if (xb_fire | ~real_time) begin
        xb_pend_reg <= 1'b0;
      end
    end
  end

  // Sync bit looked up only for first words
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sync_hit_reg <= 1'b0;
      sync_out_n   <= 1'b1;
    end else begin
      if (first_machine_phase) begin
        sync_hit_reg <= first_word & sync_mem[insn_addr];
      end
      // Stale hit masked at the strobe so it never spills into the next word
      sync_out_n <= ~(sync_hit_reg & phase_first_half & ~first_machine_phase);
    end
  end

endmodule
`default_nettype wire

// ### src/etp_pkg.sv
// Constants, register map and field layout of the trace and profile probe.
// Assumes an APB master with 32-bit data and a CPU that flags instruction words.

package etp_pkg;

  // Register byte offsets
  localparam logic [7:0] ETP_CTRL_OFS     = 8'h00;
  localparam logic [7:0] ETP_TRC_TRIG_OFS = 8'h04;
  localparam logic [7:0] ETP_CNT_TRIG_OFS = 8'h08;
  localparam logic [7:0] ETP_STATUS_OFS   = 8'h0C;
  localparam logic [7:0] ETP_CYCLES_OFS   = 8'h10;
  localparam logic [7:0] ETP_MAP_ADR_OFS  = 8'h14;
  localparam logic [7:0] ETP_MAP_DAT_OFS  = 8'h18;
  localparam logic [7:0] ETP_TRC_IDX_OFS  = 8'h1C;
  localparam logic [7:0] ETP_TRC_W0_OFS   = 8'h20;
  localparam logic [7:0] ETP_TRC_W1_OFS   = 8'h24;
  localparam logic [7:0] ETP_TRC_W2_OFS   = 8'h28;

  // Control register fields
  localparam int ETP_C_TMODE   = 0;  // 2 bits
  localparam int ETP_C_TOPT    = 2;
  localparam int ETP_C_CMODE   = 3;  // 2 bits
  localparam int ETP_C_XBRK_EN = 5;
  localparam int ETP_C_OVF_EN  = 6;
  localparam int ETP_C_TSTART  = 7;
  localparam int ETP_C_TSTOP   = 8;
  localparam int ETP_C_CSTART  = 9;
  localparam int ETP_C_CSTOP   = 10;
  localparam int ETP_CTRL_W    = 11;
  localparam logic [ETP_CTRL_W-1:0] ETP_CTRL_RST = 11'h000;

  // Per-address map bits
  localparam int ETP_M_TE   = 0;
  localparam int ETP_M_MARK = 1;
  localparam int ETP_M_SYNC = 2;

  // Trace entry layout, low to high
  localparam int ETP_E_ADDR = 0;   // 16
  localparam int ETP_E_ACC  = 16;  // 4
  localparam int ETP_E_RADR = 20;  // 12
  localparam int ETP_E_RDAT = 32;  // 4
  localparam int ETP_E_FLAG = 36;  // 3 carry/zero/general + irq enable
  localparam int ETP_E_CB   = 40;  // 4
  localparam int ETP_E_EB   = 44;  // 4
  localparam int ETP_E_HL   = 48;  // 8
  localparam int ETP_E_XY   = 56;  // 8
  localparam int ETP_E_SP   = 64;  // 5
  localparam int ETP_E_RSP  = 69;  // 4
  localparam int ETP_E_PRB  = 73;  // 4
  localparam int ETP_ENTRY_W = 77;

  // Trace and count modes
  typedef enum logic [1:0] {
    ETP_MODE_OFF,
    ETP_MODE_FREE,
    ETP_MODE_TRIG,
    ETP_MODE_RSVD
  } etp_mode_e;

endpackage

// ### src/etp_trigger.sv
// Start/stop address window shared by the trace recorder and the counter.
// Assumes insn_strobe marks the start of each fetched code word.
`timescale 1ns/10ps
`default_nettype none

module etp_trigger #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Setup
  input  wire etp_pkg::etp_mode_e mode,
  input  wire logic              start_en,
  input  wire logic              stop_en,
  input  wire logic [ADDR_W-1:0] start_addr,
  input  wire logic [ADDR_W-1:0] stop_addr,
  // Emulation events
  input  wire logic              real_time,
  input  wire logic              run_start,
  input  wire logic              brk_taken,
  input  wire logic              insn_strobe,
  input  wire logic              first_word,
  input  wire logic [ADDR_W-1:0] insn_addr,
  // Result for the instruction now starting
  output logic                   take,
  output logic                   open
);
  import etp_pkg::*;

  logic open_reg;
  logic open_next;
  wire  first   = insn_strobe & first_word;
  wire  hit_go  = first & start_en & (insn_addr == start_addr);
  wire  hit_end = first & stop_en & (insn_addr == stop_addr);
  // Stop hit excludes this instruction, start hit includes it
  wire  in_win  = hit_end ? 1'b0 : (hit_go | open_reg);
  wire  allowed = (mode == ETP_MODE_FREE) | ((mode == ETP_MODE_TRIG) & in_win);

  assign take = first & real_time & allowed;
  assign open = open_reg;

  // Window state; break closes, stop-only opens at run start
  always_comb begin
    open_next = open_reg;
    if (brk_taken) begin
      open_next = 1'b0;
    end else if (run_start & stop_en & ~start_en) begin
      open_next = 1'b1;
    end else if (real_time & hit_end) begin
      open_next = 1'b0;
    end else if (real_time & hit_go) begin
      open_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open_reg <= 1'b0;
    end else begin
      open_reg <= open_next;
    end
  end

endmodule
`default_nettype wire

// ### bench/etp_top_assertions.sv
// Port-level checker for the trace and profile probe top.
// Assumes it is bound to every etp_top instance.
`timescale 1ns/10ps
`default_nettype none
module etp_top_checker (
  // Clock, reset and APB
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timing and cable
  input wire logic        run_start,
  input wire logic        second_machine_phase,
  input wire logic        phase_first_half,
  input wire logic        sync_out_n,
  input wire logic        ext_break_req,
  input wire logic        ovf_break_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // APB answers; word offsets above the map are refused
  apb_ready_a: assert property (pready == (psel && penable)) else $error("pready wrong");
  apb_unmapped_a: assert property (psel && penable && paddr > 8'h28 |-> pslverr) else $error("no slave error");
  apb_mapped_a: assert property (psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("spurious slave error");
  apb_zero_a: assert property (psel && penable && !pwrite && paddr > 8'h28 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  ////////////////////////////////////////////////////////////
  // Break requests; the external one is tied to the second phase
  ext_pulse_a: assert property (ext_break_req |=> !ext_break_req) else $error("ext break not a pulse");
  ext_phase_a: assert property (ext_break_req |-> $past(second_machine_phase) || $past(second_machine_phase, 2))
    else $error("ext break off phase");
  ovf_hold_a: assert property (ovf_break_req && !run_start |=> ovf_break_req)
    else $error("overflow break dropped");
  // Sync low only in the first half of the first phase, one clock late
  sync_half_a: assert property (!sync_out_n |-> $past(phase_first_half)) else $error("sync low outside half");
endmodule
bind etp_top etp_top_checker u_chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .run_start, .second_machine_phase, .phase_first_half, .sync_out_n, .ext_break_req, .ovf_break_req);
`default_nettype wire

// ### bench/etp_target_model.sv
// Target board seen through the probe cable.
// Assumes the bench commands break level and probe pattern.
`timescale 1ns/10ps
`default_nettype none
module etp_target_model (
  // Commands from the bench
  input  wire logic       clk,
  input  wire logic       brk_cmd,
  input  wire logic [3:0] probe_cmd,
  // Cable pins, driven by the board at all times
  output logic            external_break_in,
  output logic [3:0]      probe_bits
);
  // Board logic changes after the clock, never at the sampling edge
  always @(posedge clk) begin
    external_break_in <= brk_cmd;
    probe_bits        <= probe_cmd;
  end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the trace and profile probe top.
// Assumes the target board model drives the cable pins.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import etp_pkg::*;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, e, oreq, xreq, sync_n;
  logic        rt = 0, rs = 0, bt = 0, fmp = 0, smp = 0, pfh = 0, fw = 0, tr = 0, ca = 0, rw = 0, brk = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] ia = 0;
  logic [1:0]  ic = 0;
  logic [3:0]  st = 0, prb = 0, pin;
  logic        xin, pready, pslverr;
  int          mismatches = 0, check_count = 0, sl = 0, xl = 0, s0, s1;
  always #50 clk = ~clk;
  // Count sync low and break pulse cycles
  always @(posedge clk) begin
    sl <= sl + (sync_n === 1'b0);
    xl <= xl + (xreq === 1'b1);
  end
  etp_target_model target_u (.clk(clk), .brk_cmd(brk), .probe_cmd(prb), .external_break_in(xin), .probe_bits(pin));
  etp_top dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .real_time(rt), .run_start(rs),
    .brk_taken(bt), .first_machine_phase(fmp), .second_machine_phase(smp), .phase_first_half(pfh),
    .first_word(fw), .table_read(tr), .insn_addr(ia), .insn_cycles(ic), .code_access(ca), .code_addr(ia),
    .cpu_acc(st), .cpu_flags_ahead(st[2:0]), .master_irq_enable_flag(st[3]), .cpu_cb(st), .cpu_eb(st),
    .cpu_hl({st, st}), .cpu_xy({st, st}), .cpu_sp({1'b0, st}), .cpu_rsp(st), .ram_write(rw),
    .ram_addr(ia[11:0]), .ram_data(st), .external_break_in(xin), .probe_trace_in_bit0(pin[0]),
    .probe_trace_in_bit1(pin[1]), .probe_trace_in_bit2(pin[2]), .probe_trace_in_bit3(pin[3]),
    .sync_out_n(sync_n), .ext_break_req(xreq), .ovf_break_req(oreq));
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // One APB transfer, waiting a bounded time for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task automatic wmap(input logic [15:0] a, input logic [31:0] d);
    apb(1, ETP_MAP_ADR_OFS, a);
    apb(1, ETP_MAP_DAT_OFS, d);
  endtask
  // One code word: first phase, then second phase, four clocks
  task automatic ins(input logic [15:0] a, input logic [1:0] c, input logic f, input logic t);
    @(posedge clk);
    fmp <= 1;
    pfh <= 1;
    fw <= f;
    tr <= t;
    ia <= a;
    ic <= c;
    ca <= 1;
    rw <= 1;
    st <= a[3:0];
    @(posedge clk);
    fmp <= 0;
    ca <= 0;
    rw <= 0;
    @(posedge clk);
    smp <= 1;
    pfh <= 0;
    @(posedge clk);
    smp <= 0;
  endtask
  task automatic pulse(input logic start);
    @(posedge clk);
    if (start) rs <= 1;
    else bt <= 1;
    @(posedge clk);
    rs <= 0;
    bt <= 0;
  endtask
  task automatic ptr(input logic [31:0] x);
    apb(0, ETP_STATUS_OFS, 0);
    chk(r[12:0], x);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(0, ETP_CTRL_OFS, 0);
    chk(r, 0);
    apb(0, 8'h40, 0);
    chk({r[30:0], e}, 1);
    $display("test regs done");
  endtask
  task automatic t_trace();
    rt <= 1;
    prb <= 4'hA;
    wmap(16'h100, 0);
    wmap(16'h101, 1);
    wmap(16'h102, 0);
    apb(1, ETP_CTRL_OFS, 1);
    pulse(1);
    ins(16'h100, 1, 1, 0);
    ins(16'h101, 1, 1, 1);
    pulse(0);
    ptr(3);
    apb(1, ETP_TRC_IDX_OFS, 0);
    apb(0, ETP_TRC_W0_OFS, 0);
    chk(r[15:0], 16'h100);
    apb(0, ETP_TRC_W2_OFS, 0);
    chk(r[12:9], 4'hA);
    apb(1, ETP_CTRL_OFS, 5);
    pulse(1);
    ins(16'h100, 1, 1, 0);
    ins(16'h101, 1, 1, 0);
    ins(16'h102, 1, 1, 0);
    ins(16'h101, 1, 0, 0);
    pulse(0);
    ptr(4);
    rt <= 0;
    ins(16'h101, 1, 1, 0);
    ptr(4);
    rt <= 1;
    apb(1, ETP_TRC_TRIG_OFS, 32'h0103_0101);
    apb(1, ETP_CTRL_OFS, 32'h182);
    pulse(1);
    ins(16'h100, 1, 1, 0);
    ins(16'h101, 1, 1, 0);
    ins(16'h103, 1, 0, 0);
    ins(16'h102, 1, 1, 0);
    ins(16'h103, 1, 1, 0);
    ins(16'h104, 1, 1, 0);
    pulse(0);
    ptr(6);
    $display("test trace done");
  endtask
  task automatic t_count();
    apb(1, ETP_CTRL_OFS, 8);
    apb(1, ETP_CYCLES_OFS, 0);
    ins(16'h200, 1, 1, 0);
    ins(16'h201, 2, 1, 0);
    ins(16'h202, 3, 1, 0);
    rt <= 0;
    ins(16'h203, 3, 1, 0);
    rt <= 1;
    apb(0, ETP_CYCLES_OFS, 0);
    chk(r, 6);
    apb(1, ETP_CNT_TRIG_OFS, 32'h0203_0200);
    apb(1, ETP_CTRL_OFS, 32'h610);
    apb(1, ETP_CYCLES_OFS, 0);
    pulse(1);
    ins(16'h1FF, 1, 1, 0);
    ins(16'h200, 2, 1, 0);
    ins(16'h201, 1, 1, 0);
    ins(16'h202, 3, 1, 0);
    ins(16'h203, 2, 1, 0);
    ins(16'h204, 1, 1, 0);
    apb(0, ETP_CYCLES_OFS, 0);
    chk(r, 6);
    apb(1, ETP_CTRL_OFS, 32'h410);
    apb(1, ETP_CYCLES_OFS, 0);
    pulse(1);
    ins(16'h202, 2, 1, 0);
    ins(16'h203, 3, 1, 0);
    apb(0, ETP_CYCLES_OFS, 0);
    chk(r, 2);
    apb(1, ETP_CTRL_OFS, 32'h48);
    apb(1, ETP_CYCLES_OFS, 32'hFF_FFFF);
    ins(16'h200, 2, 1, 0);
    apb(0, ETP_CYCLES_OFS, 0);
    chk({r[30:0], oreq}, 3);
    pulse(1);
    apb(0, ETP_STATUS_OFS, 0);
    chk(r[19], 0);
    $display("test count done");
  endtask
  task automatic t_cable();
    wmap(16'h300, 4);
    wmap(16'h301, 0);
    s0 = sl;
    ins(16'h300, 1, 1, 0);
    repeat (2) @(posedge clk);
    s1 = sl;
    ins(16'h301, 1, 1, 0);
    ins(16'h300, 1, 0, 0);
    repeat (2) @(posedge clk);
    chk({s1 > s0, sl == s1}, 3);
    apb(1, ETP_CTRL_OFS, 32'h20);
    s0 = xl;
    brk <= 1;
    ins(16'h302, 1, 1, 0);
    repeat (3) @(posedge clk);
    chk(xl - s0, 1);
    wmap(16'h401, 0);
    rt <= 0;
    ins(16'h401, 1, 1, 0);
    rt <= 1;
    ins(16'h400, 1, 1, 0);
    apb(1, ETP_MAP_ADR_OFS, 16'h401);
    apb(0, ETP_MAP_DAT_OFS, 0);
    chk(r[1], 0);
    apb(1, ETP_MAP_ADR_OFS, 16'h400);
    apb(0, ETP_MAP_DAT_OFS, 0);
    chk(r[1], 1);
    $display("test cable done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    t_regs();
    t_trace();
    t_count();
    t_cable();
    complete_run();
  end
endmodule
`default_nettype wire
